//--- include/sfsrc_link_if.sv
// spi link between the flash device end and the host end
`timescale 1ns/10ps
`default_nettype none
interface sfsrc_link_if;
	logic sck;
	logic cs_n;
	logic [2:0] h_o;
	logic [2:0] h_oe;
	logic [1:0] d_o;
	logic [1:0] d_oe;
	logic [2:0] lane;
	// device wins a lane it drives; undriven lanes float high
	assign lane[0] = d_oe[0] ? d_o[0] : (h_oe[0] ? h_o[0] : 1'b1);
	assign lane[1] = d_oe[1] ? d_o[1] : (h_oe[1] ? h_o[1] : 1'b1);
	assign lane[2] = h_oe[2] ? h_o[2] : 1'b1;
	modport dev (input sck, input cs_n, input lane, output d_o, output d_oe);
	modport host (output sck, output cs_n, output h_o, output h_oe,
		input lane);
endinterface
`default_nettype wire

//--- include/sfsrc_pkg.sv
// shared constants and types for the serial flash command block
package sfsrc_pkg;
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_VWREN = 8'h50;
	localparam logic [7:0] OP_WRDI = 8'h04;
	localparam logic [7:0] OP_RDSR1 = 8'h05;
	localparam logic [7:0] OP_RDSR2 = 8'h35;
	localparam logic [7:0] OP_WRSR1 = 8'h01;
	localparam logic [7:0] OP_WRSR2 = 8'h31;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_FREAD = 8'h0b;
	localparam logic [7:0] OP_DREAD = 8'h3b;
	localparam logic [7:0] OP_WRAP = 8'h77;
	localparam int BUSY_BIT = 0;
	localparam int WEL_BIT = 1;
	localparam logic [15:0] SR_RESET = 16'h0000;
	// writable bits: sr1 bits 7..2, sr2 bits 14..8
	localparam logic [7:0] SR1_WMASK = 8'hfc;
	localparam logic [7:0] SR2_WMASK = 8'h7f;
	// one-time bits inside sr2: lock bits 13..10
	localparam logic [15:0] OTP_MASK = 16'h3c00;
	// status lock bit, sticky only on the volatile path
	localparam logic [15:0] SRL_MASK = 16'h0100;
	// {wrap_len_hi, wrap_len_lo, wrap_enable_n}
	localparam logic [2:0] WRAP_RESET = 3'h1;
	localparam logic [5:0] HDR_OPC = 6'h08;
	localparam logic [5:0] HDR_ADDR = 6'h20;
	localparam logic [5:0] HDR_DUMMY = 6'h28;
	localparam logic [5:0] OPC_LAST = 6'h07;
	localparam logic [5:0] ADDR_LAST = 6'h1f;
	localparam logic [5:0] WRAP_NIBBLE = 6'h0e;
	localparam logic [5:0] CNT_TOP = 6'h3f;
	localparam logic [5:0] CNT_BASE = 6'h38;
	localparam logic [5:0] BITS_ONE = 6'h10;
	localparam logic [5:0] BITS_TWO = 6'h18;
	localparam int REF_PERIOD_NS = 25;
	localparam int SW_TIME_NS = 10000;
	localparam int VR_TIME_NS = 100;
	localparam int SW_CYCLES = (SW_TIME_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
	localparam int VR_CYCLES = VR_TIME_NS / REF_PERIOD_NS;
	localparam int HOST_DIV = 4;
	localparam int HOST_GAP = 4;
	typedef enum logic [1:0] {
		HST_IDLE = 2'b00,
		HST_RUN = 2'b01,
		HST_GAP = 2'b10
	} sfsrc_hst_t;
endpackage

//--- rtl/sfsrc_device.sv
// flash device end: instruction decode, status registers, reads
// Overview of operation
// - write enable opcode sets write_enable_latch
// - guarded writes need latch set first
// - volatile enable only qualifies next status write
// - write disable clears latch and volatile enable
// - latch cleared at reset and write completion
// - read status shifts register out msb first
// - status reads allowed anytime, repeat until deselect
// - status writes touch only writable bits
// - lock bits return to zero only at reset
// - non-volatile write: enable, opcode, then data
// - volatile write leaves latch at zero
// - write counts only ending after 8/16 bits
// - eight data bits after write status one update register one only
// - non-volatile write runs timed busy cycle
// - volatile write applies quickly, busy stays low
// - read data: address in, bytes out, incrementing
// - read data ignored while busy
// - fast read adds eight dummy clocks
// - dual read outputs two bits per clock
// - host releases lane zero before dual data
// - host leaves dummy clocks undriven, lanes float high
// - wrap bits taken from seventh nibble
// - lane one odd bits, lane zero even bits
`timescale 1ns/10ps
`default_nettype none
module sfsrc_device #(
	parameter logic [19:0] SW_CYC = 20'(sfsrc_pkg::SW_CYCLES),
	parameter logic [7:0] MEM_SEED = 8'h00
) (
	sfsrc_link_if.dev lnk,
	input wire logic ref_clk,
	input wire logic rst,
	output logic [15:0] status,
	output logic [2:0] wrap_cfg
);
	// header length in link clocks before output data starts
	function automatic logic [5:0] hdr_of(input logic [7:0] op);
		if (op == sfsrc_pkg::OP_READ) begin
			hdr_of = sfsrc_pkg::HDR_ADDR;
		end else if (op == sfsrc_pkg::OP_FREAD || op == sfsrc_pkg::OP_DREAD) begin
			hdr_of = sfsrc_pkg::HDR_DUMMY;
		end else begin
			hdr_of = sfsrc_pkg::HDR_OPC;
		end
	endfunction

	function automatic logic is_mem_read(input logic [7:0] op);
		is_mem_read = op == sfsrc_pkg::OP_READ || op == sfsrc_pkg::OP_FREAD ||
			op == sfsrc_pkg::OP_DREAD;
	endfunction

	// ---------------- link clock domain ----------------
	logic [5:0] cnt_q;
	logic [5:0] nbits_q;
	logic [31:0] sh_q;
	logic [7:0] opc_q;
	logic [23:0] addr_q;
	logic [2:0] wrapcap_q;
	logic ign_q;
	logic [15:0] sr_s1_q;
	logic [15:0] sr_s2_q;
	logic [1:0] do_q;
	logic [1:0] doe_q;
	logic [5:0] cnt_nx;
	logic [5:0] hdr;
	logic byte_end;

	// counter wraps inside 56..63 so low bits keep their phase
	assign cnt_nx = (cnt_q == sfsrc_pkg::CNT_TOP) ? sfsrc_pkg::CNT_BASE :
		cnt_q + 6'h01;
	assign hdr = hdr_of(opc_q);
	assign byte_end = (opc_q == sfsrc_pkg::OP_DREAD) ?
		(cnt_q[1:0] == 2'h3) : (cnt_q[2:0] == 3'h7);

	// no link edges outside a frame, so deselect clears the count
	always_ff @(posedge lnk.sck or posedge lnk.cs_n) begin
		if (lnk.cs_n) begin
			cnt_q <= 6'h00;
		end else begin
			cnt_q <= cnt_nx;
		end
	end

	// frame summary stays put after deselect for the ref domain
	always_ff @(posedge lnk.sck) begin
		nbits_q <= cnt_nx;
		sh_q <= {sh_q[30:0], lnk.lane[0]};
	end

	always_ff @(posedge lnk.sck) begin
		if (cnt_q == sfsrc_pkg::OPC_LAST) begin
			opc_q <= {sh_q[6:0], lnk.lane[0]};
			ign_q <= sr_s2_q[sfsrc_pkg::BUSY_BIT];
		end
	end

	always_ff @(posedge lnk.sck) begin
		if (cnt_q == sfsrc_pkg::ADDR_LAST) begin
			addr_q <= {sh_q[22:0], lnk.lane[0]};
		end else if (is_mem_read(opc_q) && cnt_q >= hdr && byte_end) begin
			addr_q <= addr_q + 24'h000001;
		end
	end

	always_ff @(posedge lnk.sck) begin
		if (opc_q == sfsrc_pkg::OP_WRAP && cnt_q == sfsrc_pkg::WRAP_NIBBLE) begin
			wrapcap_q <= lnk.lane[2:0];
		end
	end

	always_ff @(posedge lnk.sck) begin
		sr_s1_q <= status;
		sr_s2_q <= sr_s1_q;
	end

	// output side: lanes change on falling edges
	logic [7:0] rbyte;
	logic [7:0] sbyte;
	logic [1:0] do_d;
	logic [1:0] doe_d;

	// memory array left out: data is a function of the address
	assign rbyte = addr_q[7:0] ^ MEM_SEED;
	assign sbyte = (opc_q == sfsrc_pkg::OP_RDSR1) ? sr_s2_q[7:0] :
		sr_s2_q[15:8];

	always_comb begin
		do_d = 2'h0;
		doe_d = 2'h0;
		if (cnt_q >= hdr) begin
			unique case (opc_q)
				sfsrc_pkg::OP_RDSR1, sfsrc_pkg::OP_RDSR2: begin
					doe_d = 2'h2;
					do_d[1] = sbyte[~cnt_q[2:0]];
				end
				sfsrc_pkg::OP_READ, sfsrc_pkg::OP_FREAD: begin
					doe_d = ign_q ? 2'h0 : 2'h2;
					do_d[1] = rbyte[~cnt_q[2:0]];
				end
				sfsrc_pkg::OP_DREAD: begin
					doe_d = ign_q ? 2'h0 : 2'h3;
					do_d[1] = rbyte[{~cnt_q[1:0], 1'b1}];
					do_d[0] = rbyte[{~cnt_q[1:0], 1'b0}];
				end
				default: begin
					doe_d = 2'h0;
				end
			endcase
		end
	end

	always_ff @(negedge lnk.sck or posedge lnk.cs_n) begin
		if (lnk.cs_n) begin
			do_q <= 2'h0;
			doe_q <= 2'h0;
		end else begin
			do_q <= do_d;
			doe_q <= doe_d;
		end
	end

	assign lnk.d_o = do_q;
	assign lnk.d_oe = doe_q;

	// ---------------- reference clock domain ----------------
	logic cs_s1_q;
	logic cs_s2_q;
	logic cs_s3_q;
	logic frame_end;
	logic [15:0] sr_q;
	logic [15:0] pend_q;
	logic [19:0] tmr_q;
	logic vwe_q;
	logic [2:0] wrap_q;
	logic wr_ok;
	logic [15:0] wdat;
	logic [15:0] wmask;
	logic wr_hit;

	always_ff @(posedge ref_clk) begin
		cs_s1_q <= lnk.cs_n;
		cs_s2_q <= cs_s1_q;
		cs_s3_q <= cs_s2_q;
	end
	assign frame_end = cs_s2_q & ~cs_s3_q;

	// new status from writable bits; one-time bits stay set
	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [15:0] dat, input logic [15:0] m, input logic vol);
		logic [15:0] sticky;
		sticky = vol ? (sfsrc_pkg::OTP_MASK | sfsrc_pkg::SRL_MASK) :
			sfsrc_pkg::OTP_MASK;
		merge = ((old & ~m) | (dat & m)) | (old & sticky);
	endfunction

	// status write shapes: only exact 8 or 16 data bits count
	always_comb begin
		wr_hit = 1'b1;
		wdat = 16'h0000;
		wmask = 16'h0000;
		if (opc_q == sfsrc_pkg::OP_WRSR1 && nbits_q == sfsrc_pkg::BITS_ONE) begin
			wdat = {8'h00, sh_q[7:0]};
			wmask = {8'h00, sfsrc_pkg::SR1_WMASK};
		end else if (opc_q == sfsrc_pkg::OP_WRSR1 &&
			nbits_q == sfsrc_pkg::BITS_TWO) begin
			wdat = {sh_q[7:0], sh_q[15:8]};
			wmask = {sfsrc_pkg::SR2_WMASK, sfsrc_pkg::SR1_WMASK};
		end else if (opc_q == sfsrc_pkg::OP_WRSR2 &&
			nbits_q == sfsrc_pkg::BITS_ONE) begin
			wdat = {sh_q[7:0], 8'h00};
			wmask = {sfsrc_pkg::SR2_WMASK, 8'h00};
		end else begin
			wr_hit = 1'b0;
		end
	end
	assign wr_ok = wr_hit && (sr_q[sfsrc_pkg::WEL_BIT] || vwe_q);

	// while busy only status reads act; they touch no state here
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sr_q <= sfsrc_pkg::SR_RESET;
			pend_q <= sfsrc_pkg::SR_RESET;
			tmr_q <= 20'h00000;
			vwe_q <= 1'b0;
		end else if (sr_q[sfsrc_pkg::BUSY_BIT]) begin
			tmr_q <= tmr_q - 20'h00001;
			if (tmr_q == 20'h00001) begin
				sr_q <= pend_q;
			end
		end else if (frame_end) begin
			if (opc_q == sfsrc_pkg::OP_WREN && nbits_q == sfsrc_pkg::HDR_OPC) begin
				sr_q[sfsrc_pkg::WEL_BIT] <= 1'b1;
			end
			if (opc_q == sfsrc_pkg::OP_VWREN && nbits_q == sfsrc_pkg::HDR_OPC) begin
				vwe_q <= 1'b1;
			end
			if (opc_q == sfsrc_pkg::OP_WRDI && nbits_q == sfsrc_pkg::HDR_OPC) begin
				sr_q[sfsrc_pkg::WEL_BIT] <= 1'b0;
				vwe_q <= 1'b0;
			end
			if (wr_ok && sr_q[sfsrc_pkg::WEL_BIT]) begin
				// new bits land at cycle end with latch and busy low
				pend_q <= merge(sr_q, wdat, wmask, 1'b0) &
					~16'h0003;
				sr_q[sfsrc_pkg::BUSY_BIT] <= 1'b1;
				tmr_q <= SW_CYC;
				vwe_q <= 1'b0;
			end else if (wr_ok) begin
				sr_q <= merge(sr_q, wdat, wmask, 1'b1);
				vwe_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wrap_q <= sfsrc_pkg::WRAP_RESET;
		end else if (frame_end && !sr_q[sfsrc_pkg::BUSY_BIT] &&
			opc_q == sfsrc_pkg::OP_WRAP && nbits_q == sfsrc_pkg::BITS_ONE) begin
			wrap_q <= wrapcap_q;
		end
	end

	assign status = sr_q;
	assign wrap_cfg = wrap_q;
endmodule
`default_nettype wire

//--- rtl/sfsrc_host.sv
// spi host end: frames one instruction per command, makes the link clock
`timescale 1ns/10ps
`default_nettype none
module sfsrc_host #(
	parameter int DIV = sfsrc_pkg::HOST_DIV
) (
	sfsrc_link_if.host lnk,
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_opcode,
	input wire logic [23:0] cmd_addr,
	input wire logic [15:0] cmd_wdata,
	input wire logic [4:0] cmd_wbits,
	input wire logic [7:0] cmd_rbytes,
	output logic cmd_ready,
	output logic [7:0] rd_data,
	output logic rd_valid
);
	localparam logic [7:0] PH_RISE = 8'(DIV - 1);
	localparam logic [7:0] PH_FALL = 8'(2 * DIV - 1);

	function automatic logic has_addr(input logic [7:0] op);
		has_addr = op == sfsrc_pkg::OP_READ || op == sfsrc_pkg::OP_FREAD ||
			op == sfsrc_pkg::OP_DREAD;
	endfunction

	function automatic logic has_dummy(input logic [7:0] op);
		has_dummy = op == sfsrc_pkg::OP_FREAD || op == sfsrc_pkg::OP_DREAD;
	endfunction

	sfsrc_pkg::sfsrc_hst_t st_q;
	logic [7:0] ph_q;
	logic [11:0] clk_q;
	logic [11:0] tend_q;
	logic [11:0] rbeg_q;
	logic [11:0] all_q;
	logic [47:0] tx_q;
	logic dual_q;
	logic wrap_q;
	logic [2:0] wbit_q;
	logic [2:0] gap_q;
	logic [1:0] lane_s1_q;
	logic [1:0] lane_s2_q;
	logic sck_q;
	logic cs_n_q;
	logic [2:0] ho_q;
	logic [2:0] hoe_q;
	logic ready_q;
	logic [7:0] rx_q;
	logic [2:0] rxn_q;
	logic [7:0] rdd_q;
	logic rdv_q;
	logic [15:0] wd_al;
	logic [11:0] tend_n;
	logic [11:0] hdr_n;
	logic [11:0] all_n;
	logic [47:0] tx_n;
	logic [7:0] rx_nx;
	logic rx_take;

	// frame lengths in link clocks, fixed when the command is taken
	always_comb begin
		wd_al = cmd_wdata << (5'h10 - cmd_wbits);
		tend_n = 12'h008 + 12'(cmd_wbits);
		tx_n = {cmd_opcode, wd_al, 24'hffffff};
		if (has_addr(cmd_opcode)) begin
			tend_n = tend_n + 12'h018;
			tx_n = {cmd_opcode, cmd_addr, wd_al};
		end
		hdr_n = has_dummy(cmd_opcode) ? tend_n + 12'h008 : tend_n;
		if (cmd_opcode == sfsrc_pkg::OP_DREAD) begin
			all_n = hdr_n + {2'h0, cmd_rbytes, 2'h0};
		end else begin
			all_n = hdr_n + {1'h0, cmd_rbytes, 3'h0};
		end
	end

	// lanes come from the link domain; needs DIV of three or more
	always_ff @(posedge ref_clk) begin
		lane_s1_q <= lnk.lane[1:0];
		lane_s2_q <= lane_s1_q;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_q <= sfsrc_pkg::HST_IDLE;
			ph_q <= 8'h00;
			clk_q <= 12'h000;
			tend_q <= 12'h000;
			rbeg_q <= 12'h000;
			all_q <= 12'h000;
			tx_q <= 48'h000000000000;
			dual_q <= 1'b0;
			wrap_q <= 1'b0;
			wbit_q <= 3'h0;
			gap_q <= 3'h0;
			sck_q <= 1'b0;
			cs_n_q <= 1'b1;
			ho_q <= 3'h0;
			hoe_q <= 3'h0;
			ready_q <= 1'b0;
		end else begin
			unique case (st_q)
				sfsrc_pkg::HST_IDLE: begin
					ready_q <= 1'b1;
					if (cmd_valid && ready_q) begin
						ready_q <= 1'b0;
						cs_n_q <= 1'b0;
						st_q <= sfsrc_pkg::HST_RUN;
						ph_q <= 8'h00;
						clk_q <= 12'h000;
						tx_q <= tx_n;
						tend_q <= tend_n;
						rbeg_q <= hdr_n;
						all_q <= all_n;
						dual_q <= cmd_opcode == sfsrc_pkg::OP_DREAD;
						wrap_q <= cmd_opcode == sfsrc_pkg::OP_WRAP;
						wbit_q <= cmd_wdata[6:4];
						ho_q <= {2'h0, tx_n[47]};
						hoe_q <= 3'h1;
					end
				end
				sfsrc_pkg::HST_RUN: begin
					if (ph_q == PH_FALL) begin
						ph_q <= 8'h00;
						sck_q <= 1'b0;
						tx_q <= {tx_q[46:0], 1'b1};
						if (clk_q == all_q) begin
							cs_n_q <= 1'b1;
							ho_q <= 3'h0;
							hoe_q <= 3'h0;
							gap_q <= 3'h0;
							st_q <= sfsrc_pkg::HST_GAP;
						end else if (wrap_q && clk_q >= 12'h008) begin
							ho_q <= wbit_q;
							hoe_q <= 3'h7;
						end else if (clk_q < tend_q) begin
							ho_q <= {2'h0, tx_q[46]};
							hoe_q <= 3'h1;
						end else begin
							// let go before the device turns the lanes
							ho_q <= 3'h0;
							hoe_q <= 3'h0;
						end
					end else begin
						ph_q <= ph_q + 8'h01;
						if (ph_q == PH_RISE) begin
							sck_q <= 1'b1;
							clk_q <= clk_q + 12'h001;
						end
					end
				end
				sfsrc_pkg::HST_GAP: begin
					gap_q <= gap_q + 3'h1;
					if (gap_q == 3'(sfsrc_pkg::HOST_GAP - 1)) begin
						st_q <= sfsrc_pkg::HST_IDLE;
					end
				end
				default: begin
					st_q <= sfsrc_pkg::HST_IDLE;
				end
			endcase
		end
	end

	assign rx_take = st_q == sfsrc_pkg::HST_RUN && ph_q == PH_RISE &&
		clk_q >= rbeg_q;
	assign rx_nx = dual_q ? {rx_q[5:0], lane_s2_q} :
		{rx_q[6:0], lane_s2_q[1]};

	// read data sampled as the host raises the clock
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rx_q <= 8'h00;
			rxn_q <= 3'h0;
			rdd_q <= 8'h00;
			rdv_q <= 1'b0;
		end else begin
			rdv_q <= 1'b0;
			if (st_q == sfsrc_pkg::HST_IDLE) begin
				rxn_q <= 3'h0;
			end else if (rx_take) begin
				rx_q <= rx_nx;
				if (rxn_q == (dual_q ? 3'h3 : 3'h7)) begin
					rxn_q <= 3'h0;
					rdd_q <= rx_nx;
					rdv_q <= 1'b1;
				end else begin
					rxn_q <= rxn_q + 3'h1;
				end
			end
		end
	end

	assign lnk.sck = sck_q;
	assign lnk.cs_n = cs_n_q;
	assign lnk.h_o = ho_q;
	assign lnk.h_oe = hoe_q;
	assign cmd_ready = ready_q;
	assign rd_data = rdd_q;
	assign rd_valid = rdv_q;
endmodule
`default_nettype wire

//--- tb/serial_flash_status_read_commands_tb.sv
// self-checking bench: host end and device end joined by the link
`timescale 1ns/10ps
`default_nettype none
module serial_flash_status_read_commands_tb;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic cmd_valid = 1'b0;
	logic [7:0] cmd_opcode = 8'h00;
	logic [23:0] cmd_addr = 24'h000000;
	logic [15:0] cmd_wdata = 16'h0000;
	logic [4:0] cmd_wbits = 5'h00;
	logic [7:0] cmd_rbytes = 8'h00;
	logic cmd_ready, rd_valid;
	logic [7:0] rd_data;
	logic [15:0] status, exp_sr;
	logic [2:0] wrap_cfg;
	logic [7:0] rb [4];
	logic [7:0] r0, r1;
	int bad_count = 0;
	int num_checks = 0;
	sfsrc_link_if lnk ();
	always #12.5 ref_clk = ~ref_clk;
	// busy time above the default 400 cycles outlasts a status read or a one-byte read
	sfsrc_device #(.SW_CYC(20'h00400)) sfsrc_device_i (.lnk(lnk.dev),
		.ref_clk(ref_clk), .rst(rst), .status(status), .wrap_cfg(wrap_cfg));
	sfsrc_host #(.DIV(8)) sfsrc_host_i (.lnk(lnk.host), .ref_clk(ref_clk),
		.rst(rst), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
		.cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_wbits(cmd_wbits),
		.cmd_rbytes(cmd_rbytes), .cmd_ready(cmd_ready), .rd_data(rd_data),
		.rd_valid(rd_valid));
	sfsrc_props sfsrc_props_i (.ref_clk(ref_clk), .rst(rst), .sck(lnk.sck),
		.cs_n(lnk.cs_n), .h_oe(lnk.h_oe), .d_o(lnk.d_o), .d_oe(lnk.d_oe));
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic fail(input string m);
		bad_count++;
		$display("MISMATCH %0t %s", $time, m);
	endtask
	task automatic cmp(input logic [15:0] g, input logic [15:0] e);
		num_checks++;
		if (g !== e) fail($sformatf("got %h want %h", g, e));
	endtask
	task automatic cmd(input logic [7:0] o, input logic [23:0] a,
		input logic [15:0] wd, input logic [4:0] wb, input logic [7:0] rn);
		int k;
		int n;
		k = 0;
		n = 0;
		@(posedge ref_clk);
		cmd_valid <= 1'b1;
		cmd_opcode <= o;
		cmd_addr <= a;
		cmd_wdata <= wd;
		cmd_wbits <= wb;
		cmd_rbytes <= rn;
		do begin
			@(posedge ref_clk);
			k++;
		end while (cmd_ready !== 1'b1 && k < 100);
		cmd_valid <= 1'b0;
		do begin
			@(posedge ref_clk);
			k++;
			if (rd_valid === 1'b1 && n < 4) begin
				rb[n] = rd_data;
				n++;
			end
		end while (!(n >= rn && cmd_ready === 1'b1) && k < 8000);
		if (k >= 8000) begin
			fail("command hung");
			complete_run();
		end
	endtask
	task automatic op(input logic [7:0] o);
		cmd(o, 24'h000000, 16'h0000, 5'h00, 8'h00);
	endtask
	task automatic wait_idle();
		int k;
		k = 0;
		while (status[sfsrc_pkg::BUSY_BIT] !== 1'b0 && k < 2000) begin
			@(posedge ref_clk);
			k++;
		end
		if (k >= 2000) begin
			fail("busy stuck");
			complete_run();
		end
		repeat (sfsrc_pkg::VR_CYCLES + 1) @(posedge ref_clk);
	endtask
	function automatic logic [15:0] nxt(input logic [15:0] o,
		input logic [15:0] v, input logic vol);
		logic [15:0] m;
		m = {sfsrc_pkg::SR2_WMASK, sfsrc_pkg::SR1_WMASK};
		nxt = (o & ~m) | (v & m) | (o & sfsrc_pkg::OTP_MASK);
		if (vol) nxt = nxt | (o & sfsrc_pkg::SRL_MASK);
	endfunction
	initial begin
		logic [15:0] v;
		logic [23:0] a;
		void'($urandom(84));
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		exp_sr = sfsrc_pkg::SR_RESET;
		@(posedge ref_clk);
		cmp(status, exp_sr);
		cmp(16'(wrap_cfg), 16'(sfsrc_pkg::WRAP_RESET));
		op(sfsrc_pkg::OP_WREN);
		cmd(sfsrc_pkg::OP_RDSR1, 24'h000000, 16'h0000, 5'h00, 8'h02);
		cmp(16'(rb[0]), 16'h0002);
		cmp(16'(rb[1]), 16'h0002);
		op(sfsrc_pkg::OP_WRDI);
		cmp(status, exp_sr);
		for (int i = 0; i < 3; i++) begin
			v = (i == 2) ? 16'hffff : 16'($urandom);
			op(sfsrc_pkg::OP_WREN);
			cmd(sfsrc_pkg::OP_WRSR1, 24'h000000, v, 5'h10, 8'h00);
			cmd(sfsrc_pkg::OP_RDSR1, 24'h000000, 16'h0000, 5'h00, 8'h01);
			cmp(16'(rb[0][1:0]), 16'h0003);
			wait_idle();
			exp_sr = nxt(exp_sr, {v[7:0], v[15:8]}, 1'b0);
			cmp(status, exp_sr);
		end
		cmd(sfsrc_pkg::OP_WRSR2, 24'h000000, 16'h0000, 5'h08, 8'h00);
		wait_idle();
		cmp(status, exp_sr);
		v = 16'($urandom);
		op(sfsrc_pkg::OP_WREN);
		cmd(sfsrc_pkg::OP_WRSR1, 24'h000000, v, 5'h08, 8'h00);
		wait_idle();
		exp_sr = nxt(exp_sr, {exp_sr[15:8], v[7:0]}, 1'b0);
		cmp(status, exp_sr);
		// a frame cut mid-byte must leave everything, latch included
		op(sfsrc_pkg::OP_WREN);
		cmd(sfsrc_pkg::OP_WRSR1, 24'h000000, ~v, 5'h0c, 8'h00);
		wait_idle();
		cmp(status, exp_sr | 16'h0002);
		op(sfsrc_pkg::OP_WRDI);
		op(sfsrc_pkg::OP_VWREN);
		cmp(status, exp_sr);
		cmd(sfsrc_pkg::OP_WRSR2, 24'h000000, 16'h0000, 5'h08, 8'h00);
		cmp(16'(status[1:0]), 16'h0000);
		wait_idle();
		exp_sr = nxt(exp_sr, {8'h00, exp_sr[7:0]}, 1'b1);
		cmp(status, exp_sr);
		op(sfsrc_pkg::OP_VWREN);
		op(sfsrc_pkg::OP_WRDI);
		cmd(sfsrc_pkg::OP_WRSR1, 24'h000000, 16'h0000, 5'h08, 8'h00);
		wait_idle();
		cmp(status, exp_sr);
		a = 24'($urandom);
		cmd(sfsrc_pkg::OP_READ, a, 16'h0000, 5'h00, 8'h02);
		r0 = rb[0];
		r1 = rb[1];
		cmd(sfsrc_pkg::OP_READ, a + 24'h000001, 16'h0000, 5'h00, 8'h01);
		cmp(16'(rb[0]), 16'(r1));
		cmd(sfsrc_pkg::OP_FREAD, a, 16'h0000, 5'h00, 8'h02);
		cmp({rb[0], rb[1]}, {r0, r1});
		cmd(sfsrc_pkg::OP_DREAD, a, 16'h0000, 5'h00, 8'h02);
		cmp({rb[0], rb[1]}, {r0, r1});
		op(sfsrc_pkg::OP_WREN);
		cmd(sfsrc_pkg::OP_WRSR1, 24'h000000, 16'(exp_sr[7:0]), 5'h08, 8'h00);
		cmd(sfsrc_pkg::OP_READ, a, 16'h0000, 5'h00, 8'h01);
		cmp(16'(status[sfsrc_pkg::BUSY_BIT]), 16'h0001);
		cmp(16'(rb[0]), 16'h00ff);
		wait_idle();
		for (int j = 0; j < 8; j++) begin
			cmd(sfsrc_pkg::OP_WRAP, 24'h000000, 16'(j << 4), 5'h08, 8'h00);
			cmp(16'(wrap_cfg), 16'(j));
		end
		complete_run();
	end
endmodule
`default_nettype wire

//--- tb/sfsrc_props.sv
// link-level assertions between the flash device end and the host end
`timescale 1ns/10ps
`default_nettype none
module sfsrc_props (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic [2:0] h_oe,
	input wire logic [1:0] d_o,
	input wire logic [1:0] d_oe
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	a_no_lane_fight: assert property (!(d_oe[0] && h_oe[0]))
		else $error("lane zero driven by both ends");
	a_dual_pair: assert property (d_oe[0] |-> d_oe[1])
		else $error("lane zero driven without lane one");
	a_sel_release: assert property ($rose(cs_n) |-> ##[0:3] (d_oe == 2'h0))
		else $error("device still drives after deselect");
	a_idle_quiet: assert property (cs_n [*4] |-> (d_oe == 2'h0))
		else $error("device drives while deselected");
	// output launched on the falling edge, so sck is low when it moves
	a_fall_edge_out: assert property ((!cs_n && d_oe[1] && $changed(d_o[1]))
		|-> !sck)
		else $error("output changed while clock high");
	a_clk_idle: assert property (cs_n [*2] |-> $stable(sck))
		else $error("link clock runs outside a frame");
	a_sel_fall_low: assert property ($fell(cs_n) |-> !sck)
		else $error("select fell with clock high");
	a_sel_rise_low: assert property ($rose(cs_n) |-> !sck)
		else $error("select rose with clock high");
	a_lane2_frame: assert property (h_oe[2] |-> !cs_n)
		else $error("lane two driven outside a frame");
	c_dual: cover property (d_oe == 2'h3);
	c_single: cover property (d_oe == 2'h2);
	c_lane2: cover property (h_oe[2]);
endmodule
`default_nettype wire
